// ### hw/lds_pkg.sv
// Purpose: Shared constants and types for the LED driver serial register bank.
// Assumes: 24-bit setup and fault-flag words, eight monitored channel pairs.
// Notes:   Offsets are register indices as seen over the serial link.
package lds_pkg;
	localparam int          REG_WIDTH     = 24;
	localparam int          PAIR_COUNT    = 8;
	localparam int          CHAN_COUNT    = 16;
	localparam int          CRC_WIDTH     = 6;
	localparam logic        OFFSET_SETUP  = 1'h0;
	localparam logic        OFFSET_FAULT  = 1'h1;
	localparam int          SETUP_MON_LSB = 16;
	localparam int          FAULT_PAIR_LSB = 8;
	localparam int          FAULT_THERMAL = 7;
	localparam int          FAULT_CONFLICT = 6;
	localparam logic [6:0]  CRC_POLY      = 7'h43;
	localparam logic [23:0] SETUP_RESET   = 24'h000000;
	localparam logic [23:0] FAULT_RESET   = 24'h000000;
	localparam int          SYNC_STAGES   = 2;

	// One setup word split into its two fields
	typedef struct packed {
		logic [7:0]  monitorConfigBit;
		logic [15:0] outputSwitchBit;
	} lds_setup_type;

	// Analog fault inputs: open and short bits per monitored pair, plus one thermal bit
	typedef struct packed {
		logic [7:0] openLoad;
		logic [7:0] shortedLoad;
		logic       thermal;
	} lds_fault_in_type;
endpackage : lds_pkg

// ### hw/lds_sync.sv
// Purpose: Two-flop synchroniser with edge detection for slow link pins.
// Assumes: Inputs change far slower than mclk.
// Notes:   Edge detection looks only at the second stage and its delayed copy.
`timescale 1ns/1ps
module lds_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut,
	output logic      [WIDTH-1:0] riseOut,
	output logic      [WIDTH-1:0] fallOut
);
	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;

	// First stage feeds only the second
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			stage1_r <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
		end else begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
		end
	end

	// Edges taken after the metastability window
	assign syncOut = stage2_r;
	assign riseOut = stage2_r & ~stage3_r;
	assign fallOut = ~stage2_r & stage3_r;
endmodule : lds_sync

// ### hw/lds_regs.sv
// Purpose: Serial setup and fault-flag registers of a 16-channel LED driver.
// Assumes: Host shift and latch clocks are much slower than mclk (160 ns vs 5 ns).
// Notes:   Analog detection arrives as levels; outputs are digital controls.
//          Standby and fault levels are foreign to mclk and are synchronised here.
//          Pin controls leave through flops, one cycle behind the registers.
`timescale 1ns/1ps
module lds_regs (
	input  wire logic                      mclk,
	input  wire logic                      rstn,
	input  wire logic                      standbySel,
	input  wire logic                      shiftClock,
	input  wire logic                      latchClock,
	input  wire logic                      serialIn,
	input  wire lds_pkg::lds_fault_in_type faultIn,
	output logic                           serialOutput,
	output logic [15:0]                    switchOn,
	output logic [7:0]                     monitorActive,
	output logic                           faultPinOe
);
	// Synchronised link pins and their edges
	logic                  pinSync;
	logic [1:0]            pinRise;
	logic [1:0]            pinFall;
	logic [1:0]            pinLevel;
	logic                  pinRise_unused;
	logic                  pinFall_unused;
	logic                  standbySync;
	lds_pkg::lds_fault_in_type faultSync;
	logic                  clrAll;
	// Shift chain, setup word and sticky flags
	logic [23:0]           shiftReg_r;
	logic [23:0]           setup_r;
	logic [23:0]           flags_r;
	// Decoded configuration, live faults and read word
	logic [7:0]            openNow;
	logic [7:0]            shortNow;
	logic [7:0]            conflict;
	logic                  conflictAny;
	logic [5:0]            crc;
	logic [23:0]           readWord;
	lds_pkg::lds_setup_type setupView;
	// Next values of the registered pin controls
	logic [15:0]           switchOn_nxt;
	logic [7:0]            monitorActive_nxt;
	logic                  faultPinOe_nxt;

	// Link pins are foreign to mclk and pass two flops first
	lds_sync #(
		.WIDTH(3)
	) u_sync (
		.mclk   (mclk),
		.rstn   (rstn),
		.asyncIn({serialIn, latchClock, shiftClock}),
		.syncOut({pinSync, pinLevel}),
		.riseOut({pinRise_unused, pinRise}),
		.fallOut({pinFall_unused, pinFall})
	);

	// Standby is a pin too; two flops keep a slow edge from splitting the clear
	lds_sync #(
		.WIDTH(1)
	) u_standby_sync (
		.mclk   (mclk),
		.rstn   (rstn),
		.asyncIn(standbySel),
		.syncOut(standbySync),
		.riseOut(),
		.fallOut()
	);

	// Analog fault levels settle through two flops before any flag logic
	lds_sync #(
		.WIDTH($bits(lds_pkg::lds_fault_in_type))
	) u_fault_sync (
		.mclk   (mclk),
		.rstn   (rstn),
		.asyncIn(faultIn),
		.syncOut(faultSync),
		.riseOut(),
		.fallOut()
	);

	// Power-on reset and standby both clear everything
	// Standby acts two cycles after its pin moves, the price of the synchroniser
	assign clrAll = !rstn || standbySync;

	assign setupView = lds_pkg::lds_setup_type'(setup_r);

	// Conflict: monitor bit and odd output bit both high
	always_comb begin
		for (int p = 0; p < lds_pkg::PAIR_COUNT; p++) begin
			conflict[p] = setupView.monitorConfigBit[p] && setupView.outputSwitchBit[2*p+1];
		end
	end
	assign conflictAny = |conflict;

	// Odd pin drives only when not a monitor, or when in conflict
	always_comb begin
		for (int p = 0; p < lds_pkg::PAIR_COUNT; p++) begin
			monitorActive_nxt[p] = setupView.monitorConfigBit[p] && !conflict[p];
			switchOn_nxt[2*p]    = setupView.outputSwitchBit[2*p];
			switchOn_nxt[2*p+1]  = setupView.outputSwitchBit[2*p+1] && !monitorActive_nxt[p];
			openNow[p]           = monitorActive_nxt[p] && setupView.outputSwitchBit[2*p]
				&& faultSync.openLoad[p];
			shortNow[p]          = monitorActive_nxt[p] && setupView.outputSwitchBit[2*p]
				&& faultSync.shortedLoad[p];
		end
	end

	// CRC: 24 data bits then six zeros, divided by the polynomial
	always_comb begin
		logic [29:0] work;
		work = {setup_r, 6'h00};
		for (int i = 29; i >= lds_pkg::CRC_WIDTH; i--) begin
			if (work[i]) begin
				work[i -: 7] = work[i -: 7] ^ lds_pkg::CRC_POLY;
			end
		end
		crc = work[5:0];
	end

	// Word presented to the host at latch time
	always_comb begin
		readWord = flags_r;
		for (int p = 0; p < lds_pkg::PAIR_COUNT; p++) begin
			readWord[lds_pkg::FAULT_PAIR_LSB+2*p+1] = flags_r[lds_pkg::FAULT_PAIR_LSB+2*p+1] | openNow[p];
			readWord[lds_pkg::FAULT_PAIR_LSB+2*p]   = flags_r[lds_pkg::FAULT_PAIR_LSB+2*p] | shortNow[p];
		end
		readWord[lds_pkg::FAULT_THERMAL]  = flags_r[lds_pkg::FAULT_THERMAL] | faultSync.thermal;
		readWord[lds_pkg::FAULT_CONFLICT] = flags_r[lds_pkg::FAULT_CONFLICT] | conflictAny;
		readWord[5:0] = crc;
	end

	// Shift chain: rise samples input, fall advances output, latch reloads
	always_ff @(posedge mclk) begin
		if (clrAll) begin
			shiftReg_r <= lds_pkg::FAULT_RESET;
		end else if (pinRise[1]) begin
			shiftReg_r <= readWord;
		end else if (pinRise[0]) begin
			shiftReg_r <= {shiftReg_r[22:0], pinSync};
		end
	end

	// Serial output held in a flop; MSB shows after latch, next bit on fall
	always_ff @(posedge mclk) begin
		if (clrAll) begin
			serialOutput <= 1'b0;
		end else if (pinRise[1]) begin
			serialOutput <= readWord[23];
		end else if (pinFall[0]) begin
			serialOutput <= shiftReg_r[23];
		end
	end

	// Setup register: write-only, stored on latch rise from shifted bits
	always_ff @(posedge mclk) begin
		if (clrAll) begin
			setup_r <= lds_pkg::SETUP_RESET;
		end else if (pinRise[1]) begin
			setup_r <= shiftReg_r;
		end
	end

	// Sticky flags; a latch reads them out, clearing only faults that ended
	always_ff @(posedge mclk) begin
		if (clrAll) begin
			flags_r <= lds_pkg::FAULT_RESET;
		end else if (pinRise[1]) begin
			flags_r <= '0;
			for (int p = 0; p < lds_pkg::PAIR_COUNT; p++) begin
				flags_r[lds_pkg::FAULT_PAIR_LSB+2*p+1] <= openNow[p];
				flags_r[lds_pkg::FAULT_PAIR_LSB+2*p]   <= shortNow[p];
			end
			flags_r[lds_pkg::FAULT_THERMAL]  <= faultSync.thermal;
			flags_r[lds_pkg::FAULT_CONFLICT] <= conflictAny;
		end else begin
			// Setting wins; the checksum field is never stored
			flags_r <= readWord & 24'hffffc0;
		end
	end

	// Open-drain fault pin pulled low while any flag is set or a conflict stands
	assign faultPinOe_nxt = (|flags_r[23:6]) || conflictAny;

	// Channel switches leave through flops so no decode glitch reaches a driver
	always_ff @(posedge mclk) begin
		if (clrAll) begin
			switchOn <= '0;
		end else begin
			switchOn <= switchOn_nxt;
		end
	end

	// Monitor selection registered with the switches, so a pair never shows both modes
	always_ff @(posedge mclk) begin
		if (clrAll) begin
			monitorActive <= '0;
		end else begin
			monitorActive <= monitorActive_nxt;
		end
	end

	// Fault pin one cycle behind the flags it reports
	always_ff @(posedge mclk) begin
		if (clrAll) begin
			faultPinOe <= 1'b0;
		end else begin
			faultPinOe <= faultPinOe_nxt;
		end
	end
endmodule : lds_regs

// ### tb/lds_regs_properties.sv
// Purpose: Port assertions for the LED driver register bank.
// Assumes: Link pins hold each level far longer than the sync delay.
// Notes:   Bind follows the module.
`timescale 1ns/1ps
module lds_regs_properties (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        standbySel,
	input wire logic        shiftClock,
	input wire logic        latchClock,
	input wire logic        serialOutput,
	input wire logic [15:0] switchOn,
	input wire logic [7:0]  monitorActive,
	input wire logic        faultPinOe
);
	logic [7:0] oddSw;
	logic       calm_r;
	// Odd switch of each pair; calm_r masks the edge after reset or standby
	always_comb for (int p = 0; p < 8; p++) oddSw[p] = switchOn[2*p+1];
	always_ff @(posedge mclk) calm_r <= rstn && !standbySel;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_reset_clears: assert property ($rose(rstn) |-> !switchOn && !monitorActive && !faultPinOe) else $error("rst");
	a_standby_clears: assert property (standbySel [*3] |=> !switchOn && !monitorActive && !serialOutput) else $error("stby");
	a_standby_pin: assert property (standbySel [*4] |-> !faultPinOe) else $error("pin");
	a_conflict_mode: assert property ((monitorActive & oddSw) == 8'h00) else $error("mode");
	a_setup_latched: assert property (calm_r && !$stable(switchOn) |-> latchClock) else $error("sw");
	a_monitor_latched: assert property (calm_r && !$stable(monitorActive) |-> latchClock) else $error("mon");
	a_output_moves: assert property (calm_r && !$stable(serialOutput) |-> latchClock || !shiftClock) else $error("so");
	a_flag_holds: assert property (faultPinOe && !latchClock && !standbySel |=> faultPinOe) else $error("hold");
endmodule : lds_regs_properties
bind lds_regs lds_regs_properties i_props (.mclk, .rstn, .standbySel, .shiftClock, .latchClock, .serialOutput, .switchOn,
	.monitorActive, .faultPinOe);

// ### tb/lds_host_model.sv
// Purpose: Host end of the serial link.
// Assumes: 160 ns link clock, pins moved on falling mclk.
// Notes:   Link clocks stand still between frames.
`timescale 1ns/1ps
module lds_host_model (
	input  wire logic mclk,
	input  wire logic serialOutput,
	output logic      shiftClock,
	output logic      latchClock,
	output logic      serialIn
);
	initial {shiftClock, latchClock, serialIn} = 3'h0;
	// Bit read while shift clock is high, long after the falling edge moved it
	task automatic xfer(input logic [23:0] wr, output logic [23:0] rd);
		for (int i = 23; i >= 0; i--) begin
			serialIn = wr[i];
			repeat (16) @(negedge mclk);
			shiftClock = 1'b1;
			repeat (16) @(negedge mclk);
			rd[i] = serialOutput;
			shiftClock = 1'b0;
		end
		serialIn = ~wr[0]; // Stale data must not look valid
		repeat (16) @(negedge mclk);
		latchClock = 1'b1;
		repeat (16) @(negedge mclk);
		latchClock = 1'b0;
		repeat (16) @(negedge mclk);
	endtask : xfer
endmodule : lds_host_model

// ### tb/test_lds_regs.sv
// Purpose: Self-checking bench for lds_regs.
// Assumes: A read returns the word loaded at the previous latch.
// Notes:   Its checksum covers the setup held before that latch.
`timescale 1ns/1ps
module test_lds_regs;
	logic        mclk = 1'b0, rstn = 1'b0, standbySel = 1'b0;
	logic        shiftClock, latchClock, serialIn, serialOutput, faultPinOe;
	logic [15:0] switchOn;
	logic [7:0]  monitorActive;
	logic [23:0] rd;
	int          fail_count = 0, tests_run = 0, cycles = 0;
	lds_pkg::lds_fault_in_type faultIn = '0;
	// Clock, host and device
	always #2.5 mclk = ~mclk;
	lds_host_model i_host (.mclk, .serialOutput, .shiftClock, .latchClock, .serialIn);
	lds_regs i_dut (.mclk, .rstn, .standbySel, .shiftClock, .latchClock, .serialIn, .faultIn, .serialOutput, .switchOn,
		.monitorActive, .faultPinOe);
	task automatic check(input string what, input logic [23:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One frame; the word read back is compared when asked
	task automatic fr(input logic [23:0] w, exp, input logic chk);
		i_host.xfer(w, rd);
		if (chk) check("read", rd, exp);
	endtask : fr
	// Switches, monitor mask and fault pin
	task automatic outs(input logic [23:0] sw, mon, pin);
		check("switch", {8'h00, switchOn}, sw);
		check("monitor", {16'h0000, monitorActive}, mon);
		check("pin", {23'h000000, faultPinOe}, pin);
	endtask : outs
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// Hang guard: the run needs about 9000 cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (10) @(negedge mclk);
		rstn = 1'b1;
		repeat (4) @(negedge mclk);
		outs(24'h0, 24'h0, 24'h0);
		$display("test reset done");
		fr(24'h804000, 24'h0, 1'b0);
		outs(24'h004000, 24'h000080, 24'h0);
		faultIn = '{openLoad: 8'h80, shortedLoad: 8'h01, thermal: 1'b1};
		fr(24'h804000, 24'h0, 1'b0);
		faultIn = '0;
		fr(24'h804000, 24'h800084, 1'b1);
		fr(24'h804000, 24'h800084, 1'b1);
		fr(24'h804000, 24'h000004, 1'b1);
		$display("test flags done");
		faultIn.thermal = 1'b1;
		repeat (6) @(negedge mclk);
		check("pin", {23'h000000, faultPinOe}, 24'h1);
		standbySel = 1'b1;
		repeat (4) @(negedge mclk);
		outs(24'h0, 24'h0, 24'h0);
		faultIn = '0;
		standbySel = 1'b0;
		$display("test standby done");
		fr(24'hd70f68, 24'h0, 1'b0);
		outs(24'h000f68, 24'h0000c1, 24'h1);
		fr(24'hd70f68, 24'h0, 1'b0);
		fr(24'h0, 24'h000059, 1'b1);
		repeat (2) fr(24'h0, 24'h0, 1'b0);
		fr(24'h0, 24'h0, 1'b1);
		outs(24'h0, 24'h0, 24'h0);
		$display("test conflict done");
		wrap_up();
	end
endmodule : test_lds_regs
